/* lmc_pkg.sv */
// How it works
// - below reset level: outputs high-z, link off
// - supply above reset level enters initialization
// - leaving reset sets error bit 0, defaults
// - initialization samples address and config resistors
// - valid decode goes normal, else sleep
// - initialization keeps link off, outputs high-z
// - initialization ends within its time limit
// - bus idle timeout sends normal/undervoltage to sleep
// - go-to-sleep frame sends normal to sleep
// - sleep: outputs off, link wake-up, errors kept
// - wake needs dominant at least minimum time
// - wake acts after bus returns recessive
// - valid wake in sleep enters initialization
// - link on in normal, off in reset/init
// - reset frame: reset mode, defaults, error bit
// - normal only via init or undervoltage; drivers follow frames
// - open-load sensing on heavy channels while off
// - heavy channels switch regardless of open-load flag
// - open-load flagged only below threshold
// - undervoltage: link off, drivers kept, timer runs
package lmc_pkg;
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned INIT_TIME_US      = 100;
  localparam int unsigned INIT_CYCLES       = INIT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DECODE_DELAY_CYC  = 16;
  localparam int unsigned WAKE_MIN_US       = 30;
  localparam int unsigned WAKE_MIN_CYCLES   = WAKE_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IDLE_TIMEOUT_MS   = 4;
  localparam int unsigned IDLE_TIMEOUT_CYC  = IDLE_TIMEOUT_MS * (CLK_HZ / 1_000);
  localparam logic [2:0]  ERR_RESET_VAL     = 3'h1;
  localparam logic [7:0]  DRIVE_RESET_VAL   = 8'h00;
  localparam int unsigned HEAVY_A_IDX       = 3;
  localparam int unsigned HEAVY_B_IDX       = 7;
  localparam logic [2:0]  CODE_BAD          = 3'h7;

  typedef enum logic [5:0] {
    LMC_UNPOWERED = 6'h01,
    LMC_INIT      = 6'h02,
    LMC_NORMAL    = 6'h04,
    LMC_SLEEP     = 6'h08,
    LMC_RESET     = 6'h10,
    LMC_UNDERVOLT = 6'h20
  } lmc_mode_t;

  typedef enum logic [1:0] {
    LMC_LINK_OFF  = 2'h0,
    LMC_LINK_ON   = 2'h1,
    LMC_LINK_WAKE = 2'h2
  } lmc_link_t;

  typedef struct packed {
    logic       reset_frame;
    logic       sleep_frame;
    logic [7:0] drive;
    logic       drive_load;
  } lmc_cmd_t;

  typedef struct packed {
    lmc_link_t  link;
    logic [7:0] out_on;
    logic [7:0] out_oe;
    logic [1:0] open_load;
    logic [2:0] err;
    logic [2:0] node_addr;
    logic [2:0] config_sel;
  } lmc_stat_t;
endpackage

/* lmc_mode_ctrl.sv */
`timescale 1ns/1ps
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int unsigned INIT_LIMIT = INIT_CYCLES,
  parameter int unsigned IDLE_LIMIT = IDLE_TIMEOUT_CYC
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      supply_ok,
  input  wire logic      supply_uv,
  input  wire logic      bus_rx,
  input  wire logic      bus_recessive_high,
  input  wire logic [2:0] node_address_code,
  input  wire logic [2:0] config_code,
  input  wire logic      heavy_a_below_thr,
  input  wire logic      heavy_b_below_thr,
  input  wire lmc_cmd_t  cmd,
  output lmc_mode_t      mode,
  output lmc_stat_t      stat
);
  // three-stage synchronisers for supply, bus and open-load pin inputs
  logic [2:0] s_ok, s_uv, s_rx, s_hi, s_ola, s_olb;
  logic       ok_f, uv_f, rx_f, hi_f, ola_f, olb_f;
  always_ff @(posedge clk) begin
    s_ok  <= {s_ok[1:0], supply_ok};
    s_uv  <= {s_uv[1:0], supply_uv};
    s_rx  <= {s_rx[1:0], bus_rx};
    s_hi  <= {s_hi[1:0], bus_recessive_high};
    s_ola <= {s_ola[1:0], heavy_a_below_thr};
    s_olb <= {s_olb[1:0], heavy_b_below_thr};
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ok_f  <= 1'b0;
      uv_f  <= 1'b0;
      rx_f  <= 1'b1;
      hi_f  <= 1'b1;
      ola_f <= 1'b0;
      olb_f <= 1'b0;
    end else begin
      if (s_ok[1] == s_ok[2]) ok_f <= s_ok[2];
      if (s_uv[1] == s_uv[2]) uv_f <= s_uv[2];
      if (s_rx[1] == s_rx[2]) rx_f <= s_rx[2];
      if (s_hi[1] == s_hi[2]) hi_f <= s_hi[2];
      if (s_ola[1] == s_ola[2]) ola_f <= s_ola[2];
      if (s_olb[1] == s_olb[2]) olb_f <= s_olb[2];
    end
  end

  function automatic logic code_valid(input logic [2:0] c);
    return c != CODE_BAD;
  endfunction

  lmc_mode_t  next_mode;
  logic [31:0] init_cnt, idle_cnt, wake_cnt;
  logic        rx_prev, wake_armed;
  logic [7:0]  drive;
  logic [2:0]  err;
  logic [2:0]  node_addr, config_sel;
  logic [1:0]  open_load;

  wire fall_edge   = rx_prev & ~rx_f;
  wire idle_expire = (idle_cnt >= IDLE_LIMIT);
  wire decode_done = (init_cnt >= DECODE_DELAY_CYC);
  wire init_expire = (init_cnt >= INIT_LIMIT - 1);
  wire codes_ok    = code_valid(node_address_code) & code_valid(config_code);
  wire wake_valid  = wake_armed & rx_f & hi_f;
  wire in_init     = (mode == LMC_INIT);
  wire leave_init  = in_init & (decode_done | init_expire);

  always_comb begin
    next_mode = mode;
    if (!ok_f) begin
      next_mode = LMC_UNPOWERED;
    end else begin
      case (mode)
        LMC_UNPOWERED: next_mode = LMC_INIT;
        LMC_INIT: begin
          if (leave_init) next_mode = (decode_done && codes_ok) ? LMC_NORMAL : LMC_SLEEP;
        end
        LMC_NORMAL: begin
          if (cmd.reset_frame) next_mode = LMC_RESET;
          else if (idle_expire || cmd.sleep_frame) next_mode = LMC_SLEEP;
          else if (uv_f) next_mode = LMC_UNDERVOLT;
        end
        LMC_UNDERVOLT: begin
          if (idle_expire) next_mode = LMC_SLEEP;
          else if (!uv_f) next_mode = LMC_NORMAL;
        end
        LMC_SLEEP: begin
          if (wake_valid) next_mode = LMC_INIT;
        end
        LMC_RESET: next_mode = LMC_INIT;
        default: next_mode = LMC_UNPOWERED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) mode <= LMC_UNPOWERED;
    else mode <= next_mode;
  end

  // init timer restarts on every entry into init
  always_ff @(posedge clk) begin
    if (sys_rst || !in_init) init_cnt <= '0;
    else init_cnt <= init_cnt + 32'd1;
  end

  // idle timer: held at zero outside normal/undervoltage, cleared by falling edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_cnt <= '0;
      rx_prev  <= 1'b1;
    end else begin
      rx_prev <= rx_f;
      if ((mode != LMC_NORMAL && mode != LMC_UNDERVOLT) || fall_edge) idle_cnt <= '0;
      else if (!idle_expire) idle_cnt <= idle_cnt + 32'd1;
    end
  end

  // dominant-length qualifier; wake fires only after bus is back high
  always_ff @(posedge clk) begin
    if (sys_rst || mode != LMC_SLEEP) begin
      wake_cnt   <= '0;
      wake_armed <= 1'b0;
    end else if (!rx_f) begin
      if (wake_cnt < WAKE_MIN_CYCLES) wake_cnt <= wake_cnt + 32'd1;
      else wake_armed <= 1'b1;
    end else if (!wake_armed) begin
      wake_cnt <= '0;
    end
  end

  // err and drive registers: defaults on power-up and on reset frame
  wire to_defaults = (mode == LMC_UNPOWERED) || (mode == LMC_RESET);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err        <= ERR_RESET_VAL;
      drive      <= DRIVE_RESET_VAL;
      node_addr  <= '0;
      config_sel <= '0;
    end else begin
      if (to_defaults) begin
        err   <= ERR_RESET_VAL;
        drive <= DRIVE_RESET_VAL;
      end else if (mode == LMC_SLEEP) begin
        drive <= DRIVE_RESET_VAL;
      end else if (mode == LMC_NORMAL && cmd.drive_load) begin
        drive <= cmd.drive;
      end
      if (in_init && decode_done && !init_expire) begin
        node_addr  <= node_address_code;
        config_sel <= config_code;
      end
    end
  end

  // open-load only while heavy driver is off, only below threshold
  always_ff @(posedge clk) begin
    if (sys_rst || to_defaults) open_load <= '0;
    else if (mode == LMC_NORMAL || mode == LMC_UNDERVOLT || in_init) begin
      open_load[0] <= ~drive[HEAVY_A_IDX] & ola_f;
      open_load[1] <= ~drive[HEAVY_B_IDX] & olb_f;
    end
  end

  wire hiz     = (mode == LMC_UNPOWERED) || in_init || (mode == LMC_RESET);
  wire run_out = (mode == LMC_NORMAL) || (mode == LMC_UNDERVOLT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat <= '0;
    end else begin
      stat.link <= (next_mode == LMC_NORMAL) ? LMC_LINK_ON :
                   (next_mode == LMC_SLEEP)  ? LMC_LINK_WAKE : LMC_LINK_OFF;
      stat.out_oe     <= hiz ? 8'h00 : 8'hFF;
      stat.out_on     <= run_out ? drive : 8'h00;
      stat.open_load  <= open_load;
      stat.err        <= err;
      stat.node_addr  <= node_addr;
      stat.config_sel <= config_sel;
    end
  end
endmodule

/* lmc_properties.sv */
`timescale 1ns/1ps
module lmc_props
  import lmc_pkg::*;
#(
  parameter int unsigned INIT_LIMIT = INIT_CYCLES,
  parameter int unsigned IDLE_LIMIT = IDLE_TIMEOUT_CYC
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       bus_rx,
  input wire logic [2:0] node_address_code,
  input wire logic [2:0] config_code,
  input wire lmc_cmd_t   cmd,
  input wire lmc_mode_t  mode,
  input wire lmc_stat_t  stat
);
  int unsigned ic;
  int unsigned lc;
  int unsigned dc;
  logic        lng;
  // raw pin counts run ahead of the design's synchroniser, so bounds carry slack
  always_ff @(posedge clk) begin
    ic  <= (sys_rst || mode != LMC_INIT) ? 0 : ic + 1;
    lc  <= (sys_rst || bus_rx) ? 0 : lc + 1;
    lng <= (sys_rst || mode != LMC_SLEEP) ? 1'b0 : (lng | (lc >= WAKE_MIN_CYCLES - 4));
    dc  <= (sys_rst || !bus_rx || !(mode inside {LMC_NORMAL, LMC_UNDERVOLT})) ? 0 : dc + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_init_quiet: assert property (mode == LMC_INIT && $past(mode) == LMC_INIT |->
    stat.out_oe == 8'h00 && stat.link == LMC_LINK_OFF) else $error("init not quiet");
  chk_normal_link: assert property (mode == LMC_NORMAL |-> stat.link == LMC_LINK_ON &&
    $past(mode) inside {LMC_INIT, LMC_NORMAL, LMC_UNDERVOLT}) else $error("bad normal entry or link");
  chk_sleep_off: assert property (mode == LMC_SLEEP && $past(mode) == LMC_SLEEP |->
    stat.out_on == 8'h00 && stat.link == LMC_LINK_WAKE) else $error("sleep outputs not off");
  chk_init_limit: assert property (ic <= INIT_LIMIT) else $error("init too long");
  chk_init_exit: assert property ($past(mode) == LMC_INIT && mode inside {LMC_NORMAL, LMC_SLEEP} |->
    (mode == LMC_NORMAL) == ($past(node_address_code) != CODE_BAD && $past(config_code) != CODE_BAD))
    else $error("wrong init exit");
  chk_wake_qual: assert property ($past(mode) == LMC_SLEEP && mode == LMC_INIT |->
    lng && $past(bus_rx, 2)) else $error("wake without qualified pulse");
  chk_idle_bound: assert property (mode == LMC_NORMAL |-> dc <= IDLE_LIMIT + 8) else $error("idle overrun");
  chk_reset_cmd: assert property (mode == LMC_NORMAL && cmd.reset_frame |-> ##[1:6] mode == LMC_RESET)
    else $error("reset frame ignored");
endmodule
bind lmc_mode_ctrl lmc_props #(.INIT_LIMIT(INIT_LIMIT), .IDLE_LIMIT(IDLE_LIMIT)) lmc_props_i (.clk, .sys_rst,
  .bus_rx, .node_address_code, .config_code, .cmd, .mode, .stat);

/* lmc_lin_master.sv */
`timescale 1ns/1ps
module lmc_lin_master
  import lmc_pkg::*;
(
  input  wire logic clk,
  output logic      bus_rx,
  output logic      bus_recessive_high,
  output lmc_cmd_t  cmd
);
  initial begin
    bus_rx = 1'b1;
    cmd    = '0;
  end
  // pull-up: a released bus reads recessive, above 60 percent
  assign bus_recessive_high = bus_rx;
  task automatic dom(input int n);
    bus_rx <= 1'b0;
    repeat (n) @(posedge clk);
    bus_rx <= 1'b1;
  endtask
  // each frame opens with a break, so the slave sees bus activity
  task automatic send(input logic rf, input logic sf, input logic [7:0] d);
    dom(13);
    repeat (8) @(posedge clk);
    cmd <= '{reset_frame: rf, sleep_frame: sf, drive: d, drive_load: !(rf | sf)};
    @(posedge clk);
    cmd <= '{reset_frame: 1'b0, sleep_frame: 1'b0, drive: ~d, drive_load: 1'b0};
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top import lmc_pkg::*;;
  localparam int IL = 200;
  localparam int DL = 500;
  logic       clk, sys_rst, sok, suv, bus_rx, brh, hla, hlb;
  logic [2:0] nac, cfc, e;
  lmc_cmd_t   cmd;
  lmc_mode_t  mode;
  lmc_stat_t  stat;
  int         err_count, total_checks;
  logic [31:0] seed;
  logic [7:0] q[$];
  lmc_mode_ctrl #(.INIT_LIMIT(IL), .IDLE_LIMIT(DL)) lmc_mode_ctrl_i (.clk(clk), .sys_rst(sys_rst), .supply_ok(sok),
    .supply_uv(suv), .bus_rx(bus_rx), .bus_recessive_high(brh), .node_address_code(nac), .config_code(cfc),
    .heavy_a_below_thr(hla), .heavy_b_below_thr(hlb), .cmd(cmd), .mode(mode), .stat(stat));
  lmc_lin_master lmc_lin_master_i (.clk(clk), .bus_rx(bus_rx), .bus_recessive_high(brh), .cmd(cmd));
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (x !== g) begin
      err_count++;
      $display("[ERR] %s exp=%0h got=%0h", n, x, g);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wm(input lmc_mode_t m, input int b);
    for (int i = 0; i < b && mode !== m; i++) @(negedge clk);
    chk("mode", m, mode);
    if (mode !== m) end_sim();
  endtask
  task automatic tx(input logic rf, input logic sf, input logic [7:0] d);
    @(posedge clk);
    lmc_lin_master_i.send(rf, sf, d);
    repeat (3) @(negedge clk);
  endtask
  task automatic wake(input int n);
    @(posedge clk);
    lmc_lin_master_i.dom(n);
    @(negedge clk);
    chk("mode", LMC_SLEEP, mode);
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    {sys_rst, sok, suv, hla, hlb, nac, cfc, seed} = {5'h10, 3'h2, 3'h1, 32'hB11E};
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    @(negedge clk);
    chk("mode", LMC_UNPOWERED, mode);
    chk("oe", 0, stat.out_oe);
    chk("link", LMC_LINK_OFF, stat.link);
    @(posedge clk);
    sok <= 1;
    wm(LMC_INIT, 10);
    @(negedge clk);
    chk("oe", 0, stat.out_oe);
    chk("link", LMC_LINK_OFF, stat.link);
    wm(LMC_NORMAL, IL);
    @(negedge clk);
    chk("oe", 8'hFF, stat.out_oe);
    chk("addr", nac, stat.node_addr);
    chk("cfg", cfc, stat.config_sel);
    chk("err", ERR_RESET_VAL, stat.err);
    $display("test power-up done");
    repeat (4) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      tx(0, 0, seed[7:0]);
      chk("drive", q.pop_front(), stat.out_on);
    end
    hla <= 1;
    tx(0, 0, 8'h00);
    chk("open", 2'h1, stat.open_load);
    hlb <= 1;
    tx(0, 0, 8'h00);
    chk("open", 2'h3, stat.open_load);
    tx(0, 0, 8'h88);
    chk("drive", 8'h88, stat.out_on);
    chk("open", 2'h0, stat.open_load);
    hla <= 0;
    hlb <= 0;
    tx(1, 0, 8'h00);
    wm(LMC_NORMAL, IL + 20);
    @(negedge clk);
    chk("err", 1, stat.err[0]);
    chk("drive", DRIVE_RESET_VAL, stat.out_on);
    tx(0, 0, 8'h5A);
    e = stat.err;
    tx(0, 1, 8'h00);
    wm(LMC_SLEEP, 8);
    @(negedge clk);
    chk("drive", 0, stat.out_on);
    chk("link", LMC_LINK_WAKE, stat.link);
    chk("err", e, stat.err);
    $display("test frames done");
    wake(100);
    repeat (20) @(negedge clk);
    chk("mode", LMC_SLEEP, mode);
    cfc <= CODE_BAD;
    wake(800);
    wm(LMC_INIT, 20);
    wm(LMC_SLEEP, IL);
    cfc <= 3'h1;
    wake(800);
    wm(LMC_NORMAL, IL + 20);
    tx(0, 0, 8'h33);
    suv <= 1;
    wm(LMC_UNDERVOLT, 10);
    @(negedge clk);
    chk("link", LMC_LINK_OFF, stat.link);
    chk("drive", 8'h33, stat.out_on);
    wm(LMC_SLEEP, DL + 50);
    suv <= 0;
    wake(800);
    wm(LMC_NORMAL, IL + 20);
    repeat (3) tx(0, 0, 8'h01);
    repeat (DL - 60) @(negedge clk);
    chk("mode", LMC_NORMAL, mode);
    wm(LMC_SLEEP, 120);
    $display("test wake and idle done");
    end_sim();
  end
endmodule
